/* hdl/dpc_map.svh */
// Register map, field positions, reset values and timing counts
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH
`define DPC_CTRL_ADDR 8'h21
`define DPC_CTRL_RESET 16'h0008
`define DPC_CTRL_MASK 16'h1e4e
`define DPC_VOL_ADDR 8'h22
`define DPC_VOL_RESET 16'hc0c0
`define DPC_CHAN_ADDR 8'h23
`define DPC_CHAN_RESET 16'h0003
`define DPC_STAT_ADDR 8'h24
`define DPC_BIT_DEEMPHASIS_SELECT_LO 1
`define DPC_BIT_MUTE 3
`define DPC_BIT_OSR 6
`define DPC_BIT_UNMUTE_RAMP 9
`define DPC_BIT_RATE 10
`define DPC_BIT_SB_FILT 11
`define DPC_BIT_MONO 12
`define DPC_VOL_LEFT_LO 8
`define DPC_VOL_RIGHT_LO 0
`define DPC_CHAN_LEFT 1
`define DPC_CHAN_RIGHT 0
`define DPC_FAST_DIV 5'h01
`define DPC_SLOW_DIV 5'h1f
`define DPC_VOL_FULL 8'hc0
`define DPC_VOL_ZERO 8'h00
`endif

/* hdl/dpc_pkg.sv */
// Types for the playback digital controls
package dpc_pkg;
	typedef enum logic [1:0] {
		dpc_deemphasis_select_none = 2'b00,
		dpc_deemphasis_select_32k = 2'b01,
		dpc_deemphasis_select_44k1 = 2'b10,
		dpc_deemphasis_select_48k = 2'b11
	} dpc_deemphasis_select_t;
	typedef enum logic [1:0] {
		dpc_idle = 2'b00,
		dpc_ramp_down = 2'b01,
		dpc_ramp_up = 2'b10
	} dpc_ramp_state_t;
endpackage : dpc_pkg

/* hdl/dpc_volume_ramp.sv */
// One channel of applied-volume ramping toward a target level
`timescale 1ns/1ps
`include "dpc_map.svh"
module dpc_volume_ramp (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic step_en,
	input wire logic muted,
	input wire logic ramp_unmute,
	input wire logic [7:0] target_code,
	output logic [7:0] level,
	output logic busy
);
	// ================================================================
	// Volume state
	dpc_pkg::dpc_ramp_state_t state;
	logic [7:0] goal;
	always_comb begin
		goal = muted ? `DPC_VOL_ZERO : target_code;
	end
	// Codes above full scale count as 0 dB
	logic [7:0] goal_sat;
	always_comb begin
		goal_sat = (goal > `DPC_VOL_FULL) ? `DPC_VOL_FULL : goal;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			level <= `DPC_VOL_ZERO;
			state <= dpc_pkg::dpc_idle;
		end else if (!muted && !ramp_unmute && state != dpc_pkg::dpc_ramp_down) begin
			level <= goal_sat;
			state <= dpc_pkg::dpc_idle;
		end else if (level > goal_sat) begin
			state <= dpc_pkg::dpc_ramp_down;
			if (step_en) begin
				level <= level - 8'h01;
			end
		end else if (level < goal_sat) begin
			if (!muted && !ramp_unmute) begin
				level <= goal_sat;
				state <= dpc_pkg::dpc_idle;
			end else begin
				state <= dpc_pkg::dpc_ramp_up;
				if (step_en) begin
					level <= level + 8'h01;
				end
			end
		end else begin
			state <= dpc_pkg::dpc_idle;
		end
	end
	assign busy = (state != dpc_pkg::dpc_idle);
endmodule : dpc_volume_ramp

/* hdl/dpc_top.sv */
// Playback soft mute, mono mix and filter selection ahead of the DAC
`timescale 1ns/1ps
`include "dpc_map.svh"
module dpc_top #(
	parameter int SAMPLE_W = 24
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	input wire logic sample_strobe,
	input wire logic signed [SAMPLE_W-1:0] left_in,
	input wire logic signed [SAMPLE_W-1:0] right_in,
	output logic sample_out_valid,
	output logic signed [SAMPLE_W-1:0] left_out,
	output logic signed [SAMPLE_W-1:0] right_out,
	output logic [7:0] left_gain_code,
	output logic [7:0] right_gain_code,
	output dpc_pkg::dpc_deemphasis_select_t deemphasis_select,
	output logic sloping_stopband_select,
	output logic double_oversample_select
);
	// ================================================================
	// Register write decode
	logic ctrl_write;
	logic vol_write;
	logic chan_write;
	assign ctrl_write = reg_write && (reg_addr == `DPC_CTRL_ADDR);
	assign vol_write = reg_write && (reg_addr == `DPC_VOL_ADDR);
	assign chan_write = reg_write && (reg_addr == `DPC_CHAN_ADDR);
	// ================================================================
	// Control register, one always_ff block per field
	localparam logic [15:0] CTRL_RESET = `DPC_CTRL_RESET;
	localparam logic [15:0] VOL_RESET = `DPC_VOL_RESET;
	localparam logic [15:0] CHAN_RESET = `DPC_CHAN_RESET;
	// Unused control bits have no storage
	logic muted;
	logic ramp_unmute;
	logic slow_rate;
	logic mono_select;
	logic [1:0] deemphasis_code;
	logic stopband_field;
	logic oversample_field;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			muted <= CTRL_RESET[`DPC_BIT_MUTE];
		end else if (ctrl_write) begin
			muted <= reg_wdata[`DPC_BIT_MUTE];
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ramp_unmute <= CTRL_RESET[`DPC_BIT_UNMUTE_RAMP];
		end else if (ctrl_write) begin
			ramp_unmute <= reg_wdata[`DPC_BIT_UNMUTE_RAMP];
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			slow_rate <= CTRL_RESET[`DPC_BIT_RATE];
		end else if (ctrl_write) begin
			slow_rate <= reg_wdata[`DPC_BIT_RATE];
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mono_select <= CTRL_RESET[`DPC_BIT_MONO];
		end else if (ctrl_write) begin
			mono_select <= reg_wdata[`DPC_BIT_MONO];
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			deemphasis_code <= CTRL_RESET[`DPC_BIT_DEEMPHASIS_SELECT_LO +: 2];
		end else if (ctrl_write) begin
			deemphasis_code <= reg_wdata[`DPC_BIT_DEEMPHASIS_SELECT_LO +: 2];
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stopband_field <= CTRL_RESET[`DPC_BIT_SB_FILT];
		end else if (ctrl_write) begin
			stopband_field <= reg_wdata[`DPC_BIT_SB_FILT];
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			oversample_field <= CTRL_RESET[`DPC_BIT_OSR];
		end else if (ctrl_write) begin
			oversample_field <= reg_wdata[`DPC_BIT_OSR];
		end
	end
	// Read-back image, spare bits read as zero
	logic [15:0] dac_playback_control;
	always_comb begin
		dac_playback_control = 16'h0000;
		dac_playback_control[`DPC_BIT_DEEMPHASIS_SELECT_LO +: 2] = deemphasis_code;
		dac_playback_control[`DPC_BIT_MUTE] = muted;
		dac_playback_control[`DPC_BIT_OSR] = oversample_field;
		dac_playback_control[`DPC_BIT_UNMUTE_RAMP] = ramp_unmute;
		dac_playback_control[`DPC_BIT_RATE] = slow_rate;
		dac_playback_control[`DPC_BIT_SB_FILT] = stopband_field;
		dac_playback_control[`DPC_BIT_MONO] = mono_select;
	end
	// ================================================================
	// Volume and channel enable registers
	logic [7:0] left_volume_code;
	logic [7:0] right_volume_code;
	logic left_channel_on;
	logic right_channel_on;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			left_volume_code <= VOL_RESET[`DPC_VOL_LEFT_LO +: 8];
		end else if (vol_write) begin
			left_volume_code <= reg_wdata[`DPC_VOL_LEFT_LO +: 8];
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			right_volume_code <= VOL_RESET[`DPC_VOL_RIGHT_LO +: 8];
		end else if (vol_write) begin
			right_volume_code <= reg_wdata[`DPC_VOL_RIGHT_LO +: 8];
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			left_channel_on <= CHAN_RESET[`DPC_CHAN_LEFT];
		end else if (chan_write) begin
			left_channel_on <= reg_wdata[`DPC_CHAN_LEFT];
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			right_channel_on <= CHAN_RESET[`DPC_CHAN_RIGHT];
		end else if (chan_write) begin
			right_channel_on <= reg_wdata[`DPC_CHAN_RIGHT];
		end
	end
	// ================================================================
	// Ramp step divider on the sample rate
	logic [4:0] div_count;
	logic step_en;
	logic [4:0] div_limit;
	assign div_limit = slow_rate ? `DPC_SLOW_DIV : `DPC_FAST_DIV;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_count <= 5'h00;
		end else if (sample_strobe) begin
			if (div_count >= div_limit) begin
				div_count <= 5'h00;
			end else begin
				div_count <= div_count + 5'h01;
			end
		end
	end
	assign step_en = sample_strobe && (div_count >= div_limit);
	// ================================================================
	// Volume ramps
	logic left_busy;
	logic right_busy;
	dpc_volume_ramp u_left_ramp (
		.clock(clock),
		.rst_n(rst_n),
		.step_en(step_en),
		.muted(muted),
		.ramp_unmute(ramp_unmute),
		.target_code(left_volume_code),
		.level(left_gain_code),
		.busy(left_busy)
	);
	dpc_volume_ramp u_right_ramp (
		.clock(clock),
		.rst_n(rst_n),
		.step_en(step_en),
		.muted(muted),
		.ramp_unmute(ramp_unmute),
		.target_code(right_volume_code),
		.level(right_gain_code),
		.busy(right_busy)
	);
	// ================================================================
	// Mono mix and sample output
	logic mono_active;
	logic signed [SAMPLE_W:0] mix_sum;
	logic signed [SAMPLE_W-1:0] mix_half;
	logic signed [SAMPLE_W-1:0] next_left_out;
	logic signed [SAMPLE_W-1:0] next_right_out;
	assign mono_active = mono_select
		&& (left_channel_on != right_channel_on);
	assign mix_sum = (SAMPLE_W+1)'(left_in)
		+ (SAMPLE_W+1)'(right_in);
	assign mix_half = mix_sum[SAMPLE_W:1];
	// Disabled channels stay silent in both modes
	always_comb begin
		next_left_out = '0;
		next_right_out = '0;
		if (mono_active) begin
			if (left_channel_on) begin
				next_left_out = mix_half;
			end
			if (right_channel_on) begin
				next_right_out = mix_half;
			end
		end else begin
			if (left_channel_on) begin
				next_left_out = left_in;
			end
			if (right_channel_on) begin
				next_right_out = right_in;
			end
		end
	end
	// Outputs hold between sample strobes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			left_out <= '0;
		end else if (sample_strobe) begin
			left_out <= next_left_out;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			right_out <= '0;
		end else if (sample_strobe) begin
			right_out <= next_right_out;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sample_out_valid <= 1'b0;
		end else begin
			sample_out_valid <= sample_strobe;
		end
	end
	// ================================================================
	// Filter and oversampling selects
	// Selects follow the control fields one cycle late
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			deemphasis_select <= dpc_pkg::dpc_deemphasis_select_none;
		end else begin
			deemphasis_select <= dpc_pkg::dpc_deemphasis_select_t'(deemphasis_code);
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sloping_stopband_select <= 1'b0;
		end else begin
			sloping_stopband_select <= stopband_field;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			double_oversample_select <= 1'b0;
		end else begin
			double_oversample_select <= oversample_field;
		end
	end
	// ================================================================
	// Read port
	// Read data stand one cycle, zero otherwise
	logic [15:0] next_rdata;
	always_comb begin
		next_rdata = 16'h0000;
		if (!reg_read) begin
			next_rdata = 16'h0000;
		end else if (reg_addr == `DPC_CTRL_ADDR) begin
			next_rdata = dac_playback_control;
		end else if (reg_addr == `DPC_VOL_ADDR) begin
			next_rdata = {left_volume_code, right_volume_code};
		end else if (reg_addr == `DPC_CHAN_ADDR) begin
			next_rdata = {14'h0000, left_channel_on, right_channel_on};
		end else if (reg_addr == `DPC_STAT_ADDR) begin
			next_rdata = {right_gain_code, left_gain_code[7:2],
				right_busy, left_busy};
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= next_rdata;
		end
	end
endmodule : dpc_top

/* dv/dpc_source.sv */
// Upstream sample source model
`timescale 1ns/1ps
module dpc_source #(
	parameter int GAP = 2
) (
	input wire logic clock,
	input wire logic rst_n,
	output logic sample_strobe,
	output logic signed [23:0] left_in,
	output logic signed [23:0] right_in
);
	logic [7:0] tick;
	logic [15:0] n;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tick <= 8'h00;
			n <= 16'h0000;
			sample_strobe <= 1'b0;
			left_in <= 24'h000000;
			right_in <= 24'h000000;
		end else if (tick == 8'(GAP - 1)) begin
			tick <= 8'h00;
			n <= n + 16'h0001;
			sample_strobe <= 1'b1;
			left_in <= {n, 8'h35};
			right_in <= ~{n, 8'h9a};
		end else begin
			// Data only valid beside the strobe
			tick <= tick + 8'h01;
			sample_strobe <= 1'b0;
			left_in <= ~left_in;
			right_in <= ~right_in;
		end
	end
endmodule : dpc_source

/* dv/dpc_top_assertions.sv */
// Port checker of the playback control block
`timescale 1ns/1ps
module dpc_top_checker (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic sample_strobe,
	input wire logic sample_out_valid,
	input wire logic [7:0] left_gain_code,
	input wire logic [7:0] right_gain_code,
	input wire dpc_pkg::dpc_deemphasis_select_t deemphasis_select,
	input wire logic sloping_stopband_select,
	input wire logic double_oversample_select
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence ctrl_wr_s;
		reg_write && reg_addr == 8'h21 ##1 !(reg_write && reg_addr == 8'h21);
	endsequence
	rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 16'h0)
		else $error("read data not zero");
	ctrl_mask_a: assert property (reg_read && reg_addr == 8'h21 |=>
		(reg_rdata & 16'he1b1) == 16'h0) else $error("ctrl spare bits set");
	unmapped_a: assert property (reg_read && reg_addr > 8'h24 |=>
		reg_rdata == 16'h0) else $error("unmapped read not zero");
	sample_valid_a: assert property (sample_out_valid ==
		$past(sample_strobe)) else $error("valid not after strobe");
	gain_down_a: assert property (left_gain_code < $past(left_gain_code)
		|-> $past(left_gain_code) == left_gain_code + 8'h01)
		else $error("gain fell by more than a step");
	gain_cap_a: assert property (left_gain_code <= 8'hc0 &&
		right_gain_code <= 8'hc0) else $error("gain above full");
	deemphasis_select_copy_a: assert property (ctrl_wr_s |=>
		deemphasis_select == $past(reg_wdata[2:1], 2))
		else $error("deemphasis not copied");
	filt_osr_a: assert property (ctrl_wr_s |=>
		{sloping_stopband_select, double_oversample_select} ==
		{$past(reg_wdata[11], 2), $past(reg_wdata[6], 2)})
		else $error("filter selects not copied");
	cover property (left_gain_code < $past(left_gain_code));
	cover property (sample_out_valid);
	cover property (ctrl_wr_s);
endmodule : dpc_top_checker
bind dpc_top dpc_top_checker u_chk (.clock, .rst_n, .reg_addr, .reg_wdata,
	.reg_write, .reg_read, .reg_rdata, .sample_strobe, .sample_out_valid,
	.left_gain_code, .right_gain_code, .deemphasis_select,
	.sloping_stopband_select, .double_oversample_select);

/* dv/test_dac_playback_digital_controls.sv */
// Self-checking bench of the playback control block
`timescale 1ns/1ps
module test_dac_playback_digital_controls;
	logic clock = 0, rst_n = 0, reg_write = 0, reg_read = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
	logic sample_strobe, sample_out_valid;
	logic sloping_stopband_select, double_oversample_select;
	logic signed [23:0] left_in, right_in, left_out, right_out;
	logic [7:0] left_gain_code, right_gain_code;
	dpc_pkg::dpc_deemphasis_select_t deemphasis_select;
	int miscompares = 0, tests_run = 0, cyc = 0;
	dpc_top u_dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .sample_strobe, .left_in, .right_in,
		.sample_out_valid, .left_out, .right_out, .left_gain_code,
		.right_gain_code, .deemphasis_select, .sloping_stopband_select,
		.double_oversample_select);
	dpc_source u_src (.clock, .rst_n, .sample_strobe, .left_in, .right_in);
	initial forever #2 clock = ~clock;
	task automatic chk(string n, logic [23:0] e, logic [23:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [15:0] v);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_write <= 1'b0;
		@(posedge clock);
	endtask : wr
	task automatic rd(logic [7:0] a, logic [15:0] e);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		chk("rdata", e, reg_rdata);
		@(posedge clock);
	endtask : rd
	// Strobes counted until the left gain reaches the goal
	task automatic meas(logic [7:0] t, int n, int tol);
		int c = 0;
		while (left_gain_code !== t && c < 4000) begin
			@(posedge clock);
			if (sample_strobe) c++;
		end
		chk("ramp len", 1, c + tol >= n && c <= n + tol);
		chk("right gain", t, right_gain_code);
	endtask : meas
	task automatic smp(logic mono);
		logic signed [24:0] s;
		logic signed [23:0] l, r;
		do @(posedge clock); while (sample_strobe !== 1'b1);
		l = left_in;
		r = right_in;
		s = l + r;
		@(negedge clock);
		chk("valid", 1, sample_out_valid);
		chk("left", mono ? s[24:1] : l, left_out);
		chk("right", mono ? 24'h0 : r, right_out);
		@(posedge clock);
	endtask : smp
	task automatic results;
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			results();
		end
	end
	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(8'h21, 16'h0008);
		rd(8'h22, 16'hc0c0);
		rd(8'h23, 16'h0003);
		rd(8'h30, 16'h0000);
		chk("gain", 0, left_gain_code);
		chk("osr", 0, double_oversample_select);
		$display("reset test done");
		wr(8'h21, 16'h0000);
		meas(8'hc0, 0, 1);
		rd(8'h24, 16'hc0c0);
		wr(8'h21, 16'h0008);
		meas(8'h00, 384, 2);
		wr(8'h22, 16'h6060);
		wr(8'h21, 16'h0000);
		meas(8'h60, 0, 1);
		wr(8'h21, 16'h0008);
		meas(8'h00, 192, 2);
		wr(8'h21, 16'h0600);
		meas(8'h60, 3072, 32);
		$display("ramp test done");
		wr(8'h23, 16'h0002);
		wr(8'h21, 16'h1000);
		smp(1);
		wr(8'h23, 16'h0003);
		smp(0);
		wr(8'h22, 16'he0e0);
		meas(8'hc0, 0, 1);
		$display("mono test done");
		for (int i = 0; i < 4; i++) begin
			d = 16'(i << 1) | (i[0] ? 16'h0848 : 16'h0008);
			wr(8'h21, d);
			rd(8'h21, d);
			chk("deemphasis_select", i, deemphasis_select);
			chk("filter", i & 1, sloping_stopband_select);
			chk("osr", i & 1, double_oversample_select);
		end
		$display("select test done");
		results();
	end
endmodule : test_dac_playback_digital_controls
